// [rtl/bfs_consts.svh]
// Timing counts, codes and reset values for the bridge fault supervisor
`ifndef BFS_CONSTS_SVH
`define BFS_CONSTS_SVH

`define BFS_CLK_PERIOD_NS 20
`define BFS_SD_FILTER_NS 2000
`define BFS_SD_FILTER_CYC ((`BFS_SD_FILTER_NS + `BFS_CLK_PERIOD_NS - 1) / `BFS_CLK_PERIOD_NS)
`define BFS_WARN_FILTER_NS 1000
`define BFS_WARN_FILTER_CYC ((`BFS_WARN_FILTER_NS + `BFS_CLK_PERIOD_NS - 1) / `BFS_CLK_PERIOD_NS)
`define BFS_OC_FILTER_NS 1000
`define BFS_OC_FILTER_CYC ((`BFS_OC_FILTER_NS + `BFS_CLK_PERIOD_NS - 1) / `BFS_CLK_PERIOD_NS)
`define BFS_RELEASE_MS 100
`define BFS_RELEASE_CYC (`BFS_RELEASE_MS * 1000000 / `BFS_CLK_PERIOD_NS)
`define BFS_DELAY_TIMEOUT_MS 1500
`define BFS_DELAY_CYC (`BFS_DELAY_TIMEOUT_MS * 1000000 / `BFS_CLK_PERIOD_NS)
`define BFS_CNT_W 32
`define BFS_EVT_W 8
`define BFS_CODE_RESET 3'h0
`define BFS_WARN_BAD_A 3'h2
`define BFS_WARN_BAD_B 3'h3
`define BFS_THR_FWD 4'h9
`define BFS_THR_REV 4'h6
`define BFS_IDX_LS0 0
`define BFS_IDX_LS1 1
`define BFS_IDX_HS0 2
`define BFS_IDX_HS1 3

`endif

// [rtl/bfs_pkg.sv]
// Types shared by the bridge fault supervisor
package bfs_pkg;
	typedef logic [2:0] bfs_code_t;
	typedef enum logic [1:0] {
		BFS_TH_NORMAL = 2'b00,
		BFS_TH_SHUTDOWN = 2'b01
	} bfs_therm_e;
endpackage

// [rtl/bfs_filter.sv]
// Two-direction debounce filter with separate rise and fall counts
`timescale 1ns/10ps
`default_nettype none
module bfs_filter
	import bfs_pkg::*;
#(
	parameter int unsigned RISE_CYC = 1,
	parameter int unsigned FALL_CYC = 1,
	parameter int unsigned W = 32
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic raw_in,
	output logic filt_out
);
	logic [W-1:0] cnt;

	// Any agreeing sample restarts the count
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt <= '0;
			filt_out <= 1'b0;
		end else if (ce_in) begin
			if (raw_in == filt_out) begin
				cnt <= '0;
			end else if (filt_out ? (cnt == W'(FALL_CYC - 1)) : (cnt == W'(RISE_CYC - 1))) begin
				filt_out <= raw_in;
				cnt <= '0;
			end else begin
				cnt <= cnt + 1'b1;
			end
		end
	end

	chk_rise_after_count: assert property (@(posedge clk_in) disable iff (rst_in)
		(ce_in && !filt_out && raw_in && cnt == W'(RISE_CYC - 1)) |=> filt_out)
		else $error("filter did not rise at full count");
	chk_no_early_rise: assert property (@(posedge clk_in) disable iff (rst_in)
		(!filt_out && cnt < W'(RISE_CYC - 1)) |=> !filt_out)
		else $error("filter rose before full count");
endmodule
`default_nettype wire

// [rtl/bfs_supervisor.sv]
// Bridge fault supervisor: thermal, over-current and load-short protection
// Behaviour
// - Warning threshold code, 3 bits, reset 000; codes 010 and 011 rejected.
// - Shutdown threshold code, 3 bits, all eight codes accepted, reset 000.
// - Shutdown comparator debounced about 2 us before acting.
// - With delay option on, wait the timeout before reducing upper limit.
// - End of thermal shutdown filtered 100 ms before release.
// - Warning comparator debounced about 1 us before recording warning.
// - Low-side over-current while on, past filter, disables bridge, latches flag.
// - Low-side flags clear on enabled diagnostic read, bridge-off fall, reset.
// - High-side over-current while on, past filter, tri-states bridge, latches flag.
// - High-side flags clear on enabled diagnostic read, bridge-off fall, reset.
// - Tracking reference is opposite low-side: LS1 forward, LS0 reverse.
// - Load-short thresholds: freewheel pair upper limit, other pair on-path.
// - Load-short results stored only while validity is asserted.
// - Filtered shutdown disables bridge, drops live and latched overheat flags.
// - Cooling below warning re-engages bridge regardless of latch or counter.
// - Latched warning clears only while temperature is below warning.
`timescale 1ns/10ps
`default_nettype none
`include "bfs_consts.svh"
module bfs_supervisor
	import bfs_pkg::*;
#(
	parameter int unsigned RELEASE_CYC = `BFS_RELEASE_CYC,
	parameter int unsigned DELAY_CYC = `BFS_DELAY_CYC
) (
	input wire logic REF_CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic CE_IN,
	input wire logic [2:0] WARN_SEL_IN,
	input wire logic [2:0] SD_SEL_IN,
	input wire logic DELAY_OPTION_ENABLE_IN,
	input wire logic READ_CLEAR_ENABLE_IN,
	input wire logic DIAG_READ_IN,
	input wire logic BRIDGE_OFF_INPUT_IN,
	input wire logic REVERSE_IN,
	input wire logic WARN_CMP_IN,
	input wire logic SD_CMP_IN,
	input wire logic [1:0] LS_ON_IN,
	input wire logic [1:0] HS_ON_IN,
	input wire logic [1:0] LS_TRIP_CMP_IN,
	input wire logic [1:0] HS_TRIP_CMP_IN,
	input wire logic [3:0] LOAD_SHORT_CMP_IN,
	input wire logic LOAD_SHORT_VALID_IN,
	output logic [2:0] WARN_THR_CODE_OUT,
	output logic [2:0] SD_THR_CODE_OUT,
	output logic LIVE_OVERHEAT_FLAG_N_OUT,
	output logic LATCHED_OVERHEAT_FLAG_N_OUT,
	output logic WARN_LIVE_OUT,
	output logic WARN_LATCHED_OUT,
	output logic REDUCE_LIMIT_OUT,
	output logic [`BFS_EVT_W-1:0] SHUTDOWN_EVENT_COUNTER_OUT,
	output logic [1:0] LOW_SIDE_OVERCURRENT_FLAG_OUT,
	output logic [1:0] HIGH_SIDE_OVERCURRENT_FLAG_OUT,
	output logic BRIDGE_DISABLE_OUT,
	output logic BRIDGE_TRISTATE_OUT,
	output logic TRACK_REF_LS1_OUT,
	output logic [3:0] LOAD_SHORT_THR_UPPER_OUT,
	output logic [3:0] LOAD_SHORT_FLAG_OUT
);
	localparam int unsigned SYNC_W = 11;

	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	logic off_prev;
	logic off_fall;
	logic off_rise;
	logic warn_sync;
	logic sd_sync;
	logic off_sync;
	logic [1:0] ls_trip_sync;
	logic [1:0] hs_trip_sync;
	logic [3:0] lsd_sync;
	logic warn_filt;
	logic sd_filt;
	logic [1:0] ls_filt;
	logic [1:0] hs_filt;
	logic [1:0] ls_filt_prev;
	logic [1:0] hs_filt_prev;
	logic [1:0] ls_set;
	logic [1:0] hs_set;
	logic oc_clear;
	bfs_therm_e therm;
	bfs_therm_e next_therm;
	logic [`BFS_CNT_W-1:0] delay_cnt;
	logic delay_done;

	function automatic logic warn_code_ok(input bfs_code_t code);
		warn_code_ok = (code != `BFS_WARN_BAD_A) && (code != `BFS_WARN_BAD_B);
	endfunction

	// Pins cross two flops; only the second stage is read
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			sync_a <= '0;
			sync_b <= '0;
		end else if (CE_IN) begin
			sync_a <= {LOAD_SHORT_CMP_IN, BRIDGE_OFF_INPUT_IN, HS_TRIP_CMP_IN, LS_TRIP_CMP_IN, SD_CMP_IN, WARN_CMP_IN};
			sync_b <= sync_a;
		end
	end

	assign warn_sync = sync_b[0];
	assign sd_sync = sync_b[1];
	assign ls_trip_sync = sync_b[3:2];
	assign hs_trip_sync = sync_b[5:4];
	assign off_sync = sync_b[6];
	assign lsd_sync = sync_b[10:7];

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			off_prev <= 1'b0;
		end else if (CE_IN) begin
			off_prev <= off_sync;
		end
	end

	assign off_fall = CE_IN && off_prev && !off_sync;
	assign off_rise = CE_IN && !off_prev && off_sync;

	// Threshold codes; an undefined warning code keeps the last good one
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			WARN_THR_CODE_OUT <= `BFS_CODE_RESET;
			SD_THR_CODE_OUT <= `BFS_CODE_RESET;
		end else if (CE_IN) begin
			if (warn_code_ok(WARN_SEL_IN)) begin
				WARN_THR_CODE_OUT <= WARN_SEL_IN;
			end
			SD_THR_CODE_OUT <= SD_SEL_IN;
		end
	end

	// Shutdown: debounced rise, long filtered release
	bfs_filter #(
		.RISE_CYC(`BFS_SD_FILTER_CYC),
		.FALL_CYC(RELEASE_CYC),
		.W(`BFS_CNT_W)
	) u_sd_filter (
		.clk_in(REF_CLK_IN),
		.rst_in(SYS_RST_IN),
		.ce_in(CE_IN),
		.raw_in(sd_sync),
		.filt_out(sd_filt)
	);

	bfs_filter #(
		.RISE_CYC(`BFS_WARN_FILTER_CYC),
		.FALL_CYC(1),
		.W(`BFS_CNT_W)
	) u_warn_filter (
		.clk_in(REF_CLK_IN),
		.rst_in(SYS_RST_IN),
		.ce_in(CE_IN),
		.raw_in(warn_sync),
		.filt_out(warn_filt)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_oc
			bfs_filter #(
				.RISE_CYC(`BFS_OC_FILTER_CYC),
				.FALL_CYC(1),
				.W(`BFS_CNT_W)
			) u_ls_filter (
				.clk_in(REF_CLK_IN),
				.rst_in(SYS_RST_IN),
				.ce_in(CE_IN),
				.raw_in(ls_trip_sync[gi] && LS_ON_IN[gi]),
				.filt_out(ls_filt[gi])
			);
			bfs_filter #(
				.RISE_CYC(`BFS_OC_FILTER_CYC),
				.FALL_CYC(1),
				.W(`BFS_CNT_W)
			) u_hs_filter (
				.clk_in(REF_CLK_IN),
				.rst_in(SYS_RST_IN),
				.ce_in(CE_IN),
				.raw_in(hs_trip_sync[gi] && HS_ON_IN[gi]),
				.filt_out(hs_filt[gi])
			);
		end
	endgenerate

	// Thermal state; release also waits for the warning comparator to drop
	always_comb begin
		next_therm = therm;
		case (therm)
			BFS_TH_NORMAL: begin
				if (sd_filt) begin
					next_therm = BFS_TH_SHUTDOWN;
				end
			end
			BFS_TH_SHUTDOWN: begin
				if (!sd_filt && !warn_sync) begin
					next_therm = BFS_TH_NORMAL;
				end
			end
			default: begin
				next_therm = BFS_TH_NORMAL;
			end
		endcase
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			therm <= BFS_TH_NORMAL;
		end else if (CE_IN) begin
			therm <= next_therm;
		end
	end

	// Overheat flags, active low; set wins over clear
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			LIVE_OVERHEAT_FLAG_N_OUT <= 1'b1;
			LATCHED_OVERHEAT_FLAG_N_OUT <= 1'b1;
			SHUTDOWN_EVENT_COUNTER_OUT <= '0;
		end else if (CE_IN) begin
			LIVE_OVERHEAT_FLAG_N_OUT <= (next_therm != BFS_TH_SHUTDOWN);
			if (next_therm == BFS_TH_SHUTDOWN) begin
				LATCHED_OVERHEAT_FLAG_N_OUT <= 1'b0;
			end else if (DIAG_READ_IN || off_fall) begin
				LATCHED_OVERHEAT_FLAG_N_OUT <= 1'b1;
			end
			if (therm == BFS_TH_NORMAL && next_therm == BFS_TH_SHUTDOWN) begin
				if (SHUTDOWN_EVENT_COUNTER_OUT != {`BFS_EVT_W{1'b1}}) begin
					SHUTDOWN_EVENT_COUNTER_OUT <= SHUTDOWN_EVENT_COUNTER_OUT + 1'b1;
				end
			end else if ((DIAG_READ_IN || off_rise) && !warn_sync) begin
				SHUTDOWN_EVENT_COUNTER_OUT <= '0;
			end
		end
	end

	// Warning flags; the latch may not clear while hot
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			WARN_LIVE_OUT <= 1'b0;
			WARN_LATCHED_OUT <= 1'b0;
		end else if (CE_IN) begin
			WARN_LIVE_OUT <= warn_filt;
			if (warn_filt) begin
				WARN_LATCHED_OUT <= 1'b1;
			end else if (DIAG_READ_IN || off_fall) begin
				WARN_LATCHED_OUT <= 1'b0;
			end
		end
	end

	// Current-limit reduction timeout, restarts when the warning drops
	assign delay_done = (delay_cnt == `BFS_CNT_W'(DELAY_CYC - 1));

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			delay_cnt <= '0;
			REDUCE_LIMIT_OUT <= 1'b0;
		end else if (CE_IN) begin
			if (!warn_filt) begin
				delay_cnt <= '0;
			end else if (!delay_done) begin
				delay_cnt <= delay_cnt + 1'b1;
			end
			REDUCE_LIMIT_OUT <= warn_filt && (!DELAY_OPTION_ENABLE_IN || delay_done);
		end
	end

	// Over-current latches; a trip in the clear cycle still lands
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			ls_filt_prev <= '0;
			hs_filt_prev <= '0;
		end else if (CE_IN) begin
			ls_filt_prev <= ls_filt;
			hs_filt_prev <= hs_filt;
		end
	end

	assign ls_set = ls_filt & ~ls_filt_prev;
	assign hs_set = hs_filt & ~hs_filt_prev;
	assign oc_clear = (DIAG_READ_IN && READ_CLEAR_ENABLE_IN) || off_fall;

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			LOW_SIDE_OVERCURRENT_FLAG_OUT <= '0;
			HIGH_SIDE_OVERCURRENT_FLAG_OUT <= '0;
		end else if (CE_IN) begin
			LOW_SIDE_OVERCURRENT_FLAG_OUT <= ls_set | (LOW_SIDE_OVERCURRENT_FLAG_OUT & {2{!oc_clear}});
			HIGH_SIDE_OVERCURRENT_FLAG_OUT <= hs_set | (HIGH_SIDE_OVERCURRENT_FLAG_OUT & {2{!oc_clear}});
		end
	end

	assign BRIDGE_DISABLE_OUT = (therm == BFS_TH_SHUTDOWN) || (|LOW_SIDE_OVERCURRENT_FLAG_OUT);
	assign BRIDGE_TRISTATE_OUT = |HIGH_SIDE_OVERCURRENT_FLAG_OUT;

	// Tracking reference and load-short threshold selection per transistor
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			TRACK_REF_LS1_OUT <= 1'b1;
			LOAD_SHORT_THR_UPPER_OUT <= `BFS_THR_FWD;
		end else if (CE_IN) begin
			TRACK_REF_LS1_OUT <= !REVERSE_IN;
			LOAD_SHORT_THR_UPPER_OUT <= REVERSE_IN ? `BFS_THR_REV : `BFS_THR_FWD;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			LOAD_SHORT_FLAG_OUT <= '0;
		end else if (CE_IN && LOAD_SHORT_VALID_IN) begin
			LOAD_SHORT_FLAG_OUT <= lsd_sync;
		end
	end

	chk_warn_code_legal: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		warn_code_ok(WARN_THR_CODE_OUT))
		else $error("undefined warning code accepted");
	chk_sd_code_follow: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		CE_IN |=> SD_THR_CODE_OUT == $past(SD_SEL_IN))
		else $error("shutdown code not taken");
	chk_shutdown_entry: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN || !CE_IN)
		(therm == BFS_TH_NORMAL && sd_filt) |=> (therm == BFS_TH_SHUTDOWN) && !LIVE_OVERHEAT_FLAG_N_OUT
		&& !LATCHED_OVERHEAT_FLAG_N_OUT && BRIDGE_DISABLE_OUT)
		else $error("shutdown not entered with flags");
	chk_hot_no_release: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		(therm == BFS_TH_SHUTDOWN && (sd_filt || warn_sync)) |=> therm == BFS_TH_SHUTDOWN)
		else $error("bridge re-engaged while hot");
	chk_release_cool: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN || !CE_IN)
		(therm == BFS_TH_SHUTDOWN && !sd_filt && !warn_sync) |=> therm == BFS_TH_NORMAL)
		else $error("bridge not re-engaged after cooling");
	chk_reduce_delay: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN || !CE_IN)
		(DELAY_OPTION_ENABLE_IN && !delay_done) |=> !REDUCE_LIMIT_OUT)
		else $error("limit reduced before timeout");
	chk_reduce_now: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN || !CE_IN)
		(!DELAY_OPTION_ENABLE_IN && warn_filt) |=> REDUCE_LIMIT_OUT)
		else $error("limit not reduced at once");
	chk_ls_disable: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN || !CE_IN)
		(ls_set != 2'h0) |=> ((LOW_SIDE_OVERCURRENT_FLAG_OUT & $past(ls_set)) == $past(ls_set))
		&& BRIDGE_DISABLE_OUT)
		else $error("low-side trip not latched");
	chk_hs_tristate: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN || !CE_IN)
		(hs_set != 2'h0) |=> ((HIGH_SIDE_OVERCURRENT_FLAG_OUT & $past(hs_set)) == $past(hs_set))
		&& BRIDGE_TRISTATE_OUT)
		else $error("high-side trip not latched");
	chk_oc_clear_edge: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		(off_fall && ls_set == 2'h0 && hs_set == 2'h0) |=> LOW_SIDE_OVERCURRENT_FLAG_OUT == 2'h0
		&& HIGH_SIDE_OVERCURRENT_FLAG_OUT == 2'h0)
		else $error("flags not cleared by bridge-off fall");
	chk_read_no_clear: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		(CE_IN && DIAG_READ_IN && !READ_CLEAR_ENABLE_IN && !off_fall && LOW_SIDE_OVERCURRENT_FLAG_OUT != 2'h0)
		|=> (LOW_SIDE_OVERCURRENT_FLAG_OUT & $past(LOW_SIDE_OVERCURRENT_FLAG_OUT))
		== $past(LOW_SIDE_OVERCURRENT_FLAG_OUT))
		else $error("flag cleared with read-clear off");
	chk_off_pulse: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		off_fall |=> !off_fall)
		else $error("clear pulse longer than a cycle");
	chk_lsd_hold: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		!(CE_IN && LOAD_SHORT_VALID_IN) |=> $stable(LOAD_SHORT_FLAG_OUT))
		else $error("load-short flags changed without validity");
	chk_warn_hot_hold: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		(warn_filt && WARN_LATCHED_OUT) |=> WARN_LATCHED_OUT)
		else $error("warning latch cleared while hot");
	chk_track_ref: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN || !CE_IN)
		1'b1 |=> TRACK_REF_LS1_OUT == !$past(REVERSE_IN)
		&& LOAD_SHORT_THR_UPPER_OUT[`BFS_IDX_LS0] == !$past(REVERSE_IN))
		else $error("tracking reference wrong for direction");
endmodule
`default_nettype wire

// [testbench/bfs_host_model.sv]
// Host-side model: diagnostic reads, bridge-off pin and option bits
`timescale 1ns/10ps
`default_nettype none
module bfs_host_model (
	input wire logic clk_in,
	output logic diag_read_out,
	output logic bridge_off_out,
	output logic read_clear_enable_out,
	output logic delay_option_enable_out
);
	initial begin
		diag_read_out = 1'b0;
		bridge_off_out = 1'b0;
		read_clear_enable_out = 1'b0;
		delay_option_enable_out = 1'b0;
	end
	// Options move on the falling edge, clear of sampling
	task automatic set_opts(input logic rc, input logic dly);
		@(negedge clk_in);
		read_clear_enable_out = rc;
		delay_option_enable_out = dly;
	endtask
	// One-cycle strobe, as the serial logic gives it
	task automatic diag_read();
		@(negedge clk_in);
		diag_read_out = 1'b1;
		@(negedge clk_in);
		diag_read_out = 1'b0;
	endtask
	// Held several cycles so the synchroniser cannot miss it
	task automatic off_pulse();
		@(negedge clk_in);
		bridge_off_out = 1'b1;
		repeat (4) @(negedge clk_in);
		bridge_off_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// [testbench/bfs_supervisor_tb_top.sv]
// Self-checking bench for the bridge fault supervisor
`timescale 1ns/10ps
`default_nettype none
`include "bfs_consts.svh"
module bfs_supervisor_tb_top;
	import bfs_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	bfs_code_t warn_sel = 3'h0;
	bfs_code_t sd_sel = 3'h0;
	logic reverse = 1'b0;
	logic warn_cmp = 1'b0;
	logic sd_cmp = 1'b0;
	logic [1:0] ls_on = 2'h0;
	logic [1:0] hs_on = 2'h0;
	logic [1:0] ls_trip = 2'h0;
	logic [1:0] hs_trip = 2'h0;
	logic [3:0] lsc_cmp = 4'h0;
	logic lsc_valid = 1'b0;
	logic diag_read, bridge_off, rd_clr, dly_opt;
	logic [2:0] warn_code, sd_code;
	logic live_n, latched_n, warn_live, warn_latched, reduce, disable_b, tristate, track_ls1;
	logic [`BFS_EVT_W-1:0] evt_cnt;
	logic [1:0] ls_flag, hs_flag;
	logic [3:0] thr_upper, lsc_flags;
	int errors = 0;
	int samples_checked = 0;

	always #10 clk = ~clk;

	bfs_host_model bfs_host_model_inst (.clk_in(clk), .diag_read_out(diag_read), .bridge_off_out(bridge_off),
		.read_clear_enable_out(rd_clr), .delay_option_enable_out(dly_opt));

	// Short release and delay counts keep the run brief
	bfs_supervisor #(.RELEASE_CYC(20), .DELAY_CYC(16)) bfs_supervisor_inst (
		.REF_CLK_IN(clk), .SYS_RST_IN(rst), .CE_IN(ce), .WARN_SEL_IN(warn_sel), .SD_SEL_IN(sd_sel),
		.DELAY_OPTION_ENABLE_IN(dly_opt), .READ_CLEAR_ENABLE_IN(rd_clr), .DIAG_READ_IN(diag_read),
		.BRIDGE_OFF_INPUT_IN(bridge_off), .REVERSE_IN(reverse), .WARN_CMP_IN(warn_cmp), .SD_CMP_IN(sd_cmp),
		.LS_ON_IN(ls_on), .HS_ON_IN(hs_on), .LS_TRIP_CMP_IN(ls_trip), .HS_TRIP_CMP_IN(hs_trip),
		.LOAD_SHORT_CMP_IN(lsc_cmp), .LOAD_SHORT_VALID_IN(lsc_valid), .WARN_THR_CODE_OUT(warn_code),
		.SD_THR_CODE_OUT(sd_code), .LIVE_OVERHEAT_FLAG_N_OUT(live_n), .LATCHED_OVERHEAT_FLAG_N_OUT(latched_n),
		.WARN_LIVE_OUT(warn_live), .WARN_LATCHED_OUT(warn_latched), .REDUCE_LIMIT_OUT(reduce),
		.SHUTDOWN_EVENT_COUNTER_OUT(evt_cnt), .LOW_SIDE_OVERCURRENT_FLAG_OUT(ls_flag),
		.HIGH_SIDE_OVERCURRENT_FLAG_OUT(hs_flag), .BRIDGE_DISABLE_OUT(disable_b), .BRIDGE_TRISTATE_OUT(tristate),
		.TRACK_REF_LS1_OUT(track_ls1), .LOAD_SHORT_THR_UPPER_OUT(thr_upper), .LOAD_SHORT_FLAG_OUT(lsc_flags));

	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Inputs only move on the falling edge
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic print_verdict();
		if (errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Hang guard, far beyond the roughly 560 cycles needed
	initial begin
		#200000;
		errors++;
		print_verdict();
	end

	initial begin
		cyc(16);
		rst = 1'b0;
		cyc(1);
		check(warn_code, 9'h0);
		check(sd_code, 9'h0);
		check({live_n, latched_n, disable_b, tristate}, 9'hC);
		check({ls_flag, hs_flag}, 9'h0);
		check({track_ls1, thr_upper}, 9'h19);
		// Codes 2 and 3 follow code 1, so code 1 must survive them
		for (int c = 0; c < 8; c++) begin
			warn_sel = c[2:0];
			sd_sel = c[2:0];
			cyc(2);
			check(sd_code, {6'h0, c[2:0]});
			check(warn_code, (c == 2 || c == 3) ? 9'h1 : {6'h0, c[2:0]});
		end
		reverse = 1'b1;
		cyc(2);
		check({track_ls1, thr_upper}, 9'h06);
		reverse = 1'b0;
		cyc(2);
		check({track_ls1, thr_upper}, 9'h19);
		// Clock enable low must freeze the accepted code
		ce = 1'b0;
		sd_sel = 3'h2;
		cyc(3);
		check(sd_code, 9'h7);
		ce = 1'b1;
		cyc(2);
		check(sd_code, 9'h2);
		lsc_cmp = 4'hA;
		cyc(5);
		check(lsc_flags, 9'h0);
		lsc_valid = 1'b1;
		cyc(1);
		lsc_valid = 1'b0;
		lsc_cmp = 4'h5;
		cyc(5);
		check(lsc_flags, 9'hA);
		// A trip on a transistor that is off must be ignored
		ls_trip = 2'b10;
		cyc(60);
		check({ls_flag, disable_b}, 9'h0);
		ls_on = 2'b10;
		cyc(45);
		check({ls_flag, disable_b}, 9'h0);
		cyc(15);
		check({ls_flag, disable_b}, 9'h5);
		ls_trip = 2'b00;
		bfs_host_model_inst.diag_read();
		cyc(2);
		check({ls_flag, disable_b}, 9'h5);
		bfs_host_model_inst.set_opts(1'b1, 1'b0);
		bfs_host_model_inst.diag_read();
		cyc(2);
		check({ls_flag, disable_b}, 9'h0);
		hs_on = 2'b01;
		hs_trip = 2'b01;
		cyc(45);
		check({hs_flag, tristate}, 9'h0);
		cyc(15);
		check({hs_flag, tristate}, 9'h3);
		hs_trip = 2'b00;
		bfs_host_model_inst.off_pulse();
		cyc(2);
		check({hs_flag, tristate}, 9'h3);
		cyc(4);
		check({hs_flag, tristate}, 9'h0);
		sd_cmp = 1'b1;
		cyc(95);
		check({live_n, disable_b}, 9'h2);
		cyc(15);
		check({live_n, latched_n, disable_b}, 9'h1);
		sd_cmp = 1'b0;
		cyc(15);
		check(disable_b, 9'h1);
		cyc(20);
		check({live_n, latched_n, disable_b}, 9'h4);
		check(evt_cnt, 9'h1);
		bfs_host_model_inst.diag_read();
		cyc(2);
		check({latched_n, evt_cnt}, 9'h100);
		warn_cmp = 1'b1;
		cyc(45);
		check({warn_live, reduce}, 9'h0);
		cyc(15);
		check({warn_live, warn_latched, reduce}, 9'h7);
		bfs_host_model_inst.diag_read();
		cyc(2);
		check(warn_latched, 9'h1);
		warn_cmp = 1'b0;
		cyc(6);
		bfs_host_model_inst.diag_read();
		cyc(2);
		check({warn_live, warn_latched}, 9'h0);
		bfs_host_model_inst.set_opts(1'b1, 1'b1);
		warn_cmp = 1'b1;
		cyc(60);
		check({warn_live, reduce}, 9'h2);
		cyc(20);
		check(reduce, 9'h1);
		warn_cmp = 1'b0;
		cyc(2);
		print_verdict();
	end
endmodule
`default_nettype wire
